// *** inc/dma_pkg.sv ***
// constants, types and helpers shared by the peripheral dma channel pair
package dma_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses on the register port)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_RX_PTR = 12'h100;
    localparam logic [11:0] OFS_RX_CNT = 12'h104;
    localparam logic [11:0] OFS_TX_PTR = 12'h108;
    localparam logic [11:0] OFS_TX_CNT = 12'h10c;
    localparam logic [11:0] OFS_RX_NPTR = 12'h110;
    localparam logic [11:0] OFS_RX_NCNT = 12'h114;
    localparam logic [11:0] OFS_TX_NPTR = 12'h118;
    localparam logic [11:0] OFS_TX_NCNT = 12'h11c;
    localparam logic [11:0] OFS_CMD = 12'h120;
    localparam logic [11:0] OFS_STATE = 12'h124;
    localparam logic [11:0] OFS_SIZE = 12'h128;
    localparam logic [11:0] OFS_EVT_STAT = 12'h130;
    localparam logic [11:0] OFS_EVT_CLR = 12'h134;
    localparam logic [11:0] OFS_EVT_EN = 12'h138;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int CMD_RX_ON = 0;
    localparam int CMD_RX_OFF = 1;
    localparam int CMD_TX_ON = 8;
    localparam int CMD_TX_OFF = 9;
    localparam int STATE_RX = 0;
    localparam int STATE_TX = 8;
    localparam int SIZE_RX_LSB = 0;
    localparam int SIZE_TX_LSB = 8;
    localparam int EVT_RX_DONE = 0;
    localparam int EVT_RX_ALL = 1;
    localparam int EVT_TX_DONE = 2;
    localparam int EVT_TX_ALL = 3;
    localparam int EVT_W = 4;
    localparam int CNT_W = 16;
    localparam logic [31:0] RST_PTR = 32'h0000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [3:0] RST_EVT = 4'h0;
    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } xfer_size_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX = 2'b01,
        ST_TX = 2'b10
    } eng_state_t;
    typedef struct packed {
        logic curPtr;
        logic curCnt;
        logic nxtPtr;
        logic nxtCnt;
    } chan_wr_t;
    typedef struct packed {
        logic [31:0] curPtr;
        logic [15:0] curCnt;
        logic [31:0] nxtPtr;
        logic [15:0] nxtCnt;
        logic endFlag;
        logic allDone;
    } chan_st_t;
    typedef struct packed {
        logic [31:0] addr;
        xfer_size_t size;
        logic isTx;
    } mem_req_t;

    // pointer increment per transfer; the unused code acts as a word
    function automatic logic [31:0] ptrStep(input xfer_size_t s);
        case (s)
            SZ_BYTE: ptrStep = 32'h0000_0001;
            SZ_HALF: ptrStep = 32'h0000_0002;
            default: ptrStep = 32'h0000_0004;
        endcase
    endfunction : ptrStep
endpackage : dma_pkg

// *** hw/dma_channel.sv ***
// one direction: current and following pointer/count with end flag
`timescale 1ns/1ns
module dma_channel
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // software writes
    input chan_wr_t wr,
    input wire logic [31:0] wrData,
    // engine side
    input wire logic step,
    input xfer_size_t size,
    // state out
    output chan_st_t st,
    output logic doneEvt
);
    logic [31:0] ptr_r, ptr_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [31:0] nptr_r, nptr_nxt;
    logic [15:0] ncnt_r, ncnt_nxt;
    logic end_r, end_nxt;

    // ------------------------------------------------------------------
    // next state: step, software writes, chaining
    // ------------------------------------------------------------------
    always_comb begin
        ptr_nxt = ptr_r;
        cnt_nxt = cnt_r;
        nptr_nxt = nptr_r;
        ncnt_nxt = ncnt_r;
        end_nxt = end_r;
        doneEvt = 1'b0;
        // a step on an empty count is dropped, nothing to transfer
        if (step && cnt_r != RST_CNT) begin
            ptr_nxt = ptr_r + ptrStep(size);
            cnt_nxt = cnt_r - 16'h0001;
        end
        // a write in the same cycle overrides the step
        if (wr.curPtr) ptr_nxt = wrData;
        if (wr.curCnt) cnt_nxt = wrData[CNT_W-1:0];
        if (wr.nxtPtr) nptr_nxt = wrData;
        if (wr.nxtCnt) ncnt_nxt = wrData[CNT_W-1:0];
        if (wr.curCnt || wr.nxtCnt) end_nxt = 1'b0;
        if (step && cnt_r == 16'h0001 && !wr.curCnt) doneEvt = 1'b1;
        // empty buffer with a following one waiting: chain it in
        if (cnt_nxt == RST_CNT && ncnt_nxt != RST_CNT) begin
            ptr_nxt = nptr_nxt;
            cnt_nxt = ncnt_nxt;
            ncnt_nxt = RST_CNT;
        end
        if (doneEvt) end_nxt = 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ptr_r <= RST_PTR;
            cnt_r <= RST_CNT;
            nptr_r <= RST_PTR;
            ncnt_r <= RST_CNT;
            end_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            cnt_r <= cnt_nxt;
            nptr_r <= nptr_nxt;
            ncnt_r <= ncnt_nxt;
            end_r <= end_nxt;
        end
    end

    // both buffers used up is a pure level of the counts
    assign st.curPtr = ptr_r;
    assign st.curCnt = cnt_r;
    assign st.nxtPtr = nptr_r;
    assign st.nxtCnt = ncnt_r;
    assign st.endFlag = end_r;
    assign st.allDone = (cnt_r == RST_CNT) && (ncnt_r == RST_CNT);
endmodule : dma_channel

// *** hw/peripheral_dma_next_buffer_ctrl.sv ***
// receive/transmit dma channel pair with chained buffers and registers
// How it works
// - transmit count is sixteen bits, transfers left in current buffer
// - transmit count zero: no more transmit transfers are issued
// - receive following address is used when current receive buffer fills
// - receive following length sits in bits 15..0
// - transmit following address is used when current transmit buffer empties
// - transmit following length sits in bits 15..0
// - command bit 0 turns receive requests on unless bit 1 too
// - command bit 1 turns receive requests off and wins
// - command bit 8 turns transmit requests on
// - command bit 9 turns transmit requests off
// - state bit 0 reads receive requests on
// - state bit 8 reads transmit requests on
// - count at zero loads following address/length, then clears following length
// - each transfer steps pointer by 1, 2 or 4, count minus one
// - end flag at count zero; all-done when both counts zero
// - writing either count of a direction clears its end flag; a following-count write in the cycle the count steps to zero leaves it set
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module peripheral_dma_next_buffer_ctrl
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // serial peripheral
    input wire logic rxReady,
    input wire logic txReady,
    output logic rxBufferDone,
    output logic rxAllBuffersDone,
    output logic txBufferDone,
    output logic txAllBuffersDone,
    // memory transfer port
    output logic memReqValid,
    output mem_req_t memReq,
    input wire logic memDone,
    // interrupt
    output logic irq
);
    // address match, shared by the decode and the checks
    function automatic logic isHit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
        isHit = (a == ofs);
    endfunction : isHit

    // ------------------------------------------------------------------
    // channel instances
    // ------------------------------------------------------------------
    chan_wr_t rxWr, txWr;
    chan_st_t rxSt, txSt;
    logic rxStep, txStep, rxDoneEvt, txDoneEvt;
    xfer_size_t rxSize_r, rxSize_nxt, txSize_r, txSize_nxt;

    // write strobes per channel register
    always_comb begin
        rxWr.curPtr = regWr && isHit(regAddr, OFS_RX_PTR);
        rxWr.curCnt = regWr && isHit(regAddr, OFS_RX_CNT);
        rxWr.nxtPtr = regWr && isHit(regAddr, OFS_RX_NPTR);
        rxWr.nxtCnt = regWr && isHit(regAddr, OFS_RX_NCNT);
        txWr.curPtr = regWr && isHit(regAddr, OFS_TX_PTR);
        txWr.curCnt = regWr && isHit(regAddr, OFS_TX_CNT);
        txWr.nxtPtr = regWr && isHit(regAddr, OFS_TX_NPTR);
        txWr.nxtCnt = regWr && isHit(regAddr, OFS_TX_NCNT);
    end

    dma_channel rxChan (
        .clk(clk),
        .reset(reset),
        .wr(rxWr),
        .wrData(regWrData),
        .step(rxStep),
        .size(rxSize_r),
        .st(rxSt),
        .doneEvt(rxDoneEvt)
    );

    dma_channel txChan (
        .clk(clk),
        .reset(reset),
        .wr(txWr),
        .wrData(regWrData),
        .step(txStep),
        .size(txSize_r),
        .st(txSt),
        .doneEvt(txDoneEvt)
    );

    // ------------------------------------------------------------------
    // request enables and transfer sizes
    // ------------------------------------------------------------------
    logic rxOn_r, rxOn_nxt, txOn_r, txOn_nxt;
    logic cmdWr, sizeWr;

    assign cmdWr = regWr && isHit(regAddr, OFS_CMD);
    assign sizeWr = regWr && isHit(regAddr, OFS_SIZE);

    // off is checked last so it wins over on in the same write
    always_comb begin
        rxOn_nxt = rxOn_r;
        txOn_nxt = txOn_r;
        rxSize_nxt = rxSize_r;
        txSize_nxt = txSize_r;
        if (cmdWr && regWrData[CMD_RX_ON]) rxOn_nxt = 1'b1;
        if (cmdWr && regWrData[CMD_RX_OFF]) rxOn_nxt = 1'b0;
        if (cmdWr && regWrData[CMD_TX_ON]) txOn_nxt = 1'b1;
        if (cmdWr && regWrData[CMD_TX_OFF]) txOn_nxt = 1'b0;
        if (sizeWr) begin
            rxSize_nxt = xfer_size_t'(regWrData[SIZE_RX_LSB+:2]);
            txSize_nxt = xfer_size_t'(regWrData[SIZE_TX_LSB+:2]);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxOn_r <= 1'b0;
            txOn_r <= 1'b0;
            rxSize_r <= SZ_BYTE;
            txSize_r <= SZ_BYTE;
        end else begin
            rxOn_r <= rxOn_nxt;
            txOn_r <= txOn_nxt;
            rxSize_r <= rxSize_nxt;
            txSize_r <= txSize_nxt;
        end
    end

    // ------------------------------------------------------------------
    // transfer engine: one transfer in flight, receive served first
    // ------------------------------------------------------------------
    eng_state_t state_r, state_nxt;
    mem_req_t req_r, req_nxt;

    // disabling mid-transfer lets the transfer in flight finish
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        rxStep = 1'b0;
        txStep = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (rxOn_r && rxReady && rxSt.curCnt != RST_CNT) begin
                    state_nxt = ST_RX;
                    req_nxt = '{addr: rxSt.curPtr, size: rxSize_r,
                                isTx: 1'b0};
                end else if (txOn_r && txReady &&
                             txSt.curCnt != RST_CNT) begin
                    state_nxt = ST_TX;
                    req_nxt = '{addr: txSt.curPtr, size: txSize_r,
                                isTx: 1'b1};
                end
            end
            ST_RX: begin
                if (memDone) begin
                    rxStep = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_TX: begin
                if (memDone) begin
                    txStep = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            req_r <= '0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
        end
    end

    assign memReqValid = (state_r != ST_IDLE);
    assign memReq = req_r;

    // ------------------------------------------------------------------
    // event status, clear and enable
    // ------------------------------------------------------------------
    logic [EVT_W-1:0] evtStat_r, evtStat_nxt, evtEn_r, evtEn_nxt;
    logic [EVT_W-1:0] evtSet, evtClr;
    logic rxAll_r, txAll_r;

    // all-done edges; the old value resets high so reset is no event
    always_comb begin
        evtSet = RST_EVT;
        evtSet[EVT_RX_DONE] = rxDoneEvt;
        evtSet[EVT_RX_ALL] = rxSt.allDone && !rxAll_r;
        evtSet[EVT_TX_DONE] = txDoneEvt;
        evtSet[EVT_TX_ALL] = txSt.allDone && !txAll_r;
        evtClr = RST_EVT;
        if (regWr && isHit(regAddr, OFS_EVT_CLR))
            evtClr = regWrData[EVT_W-1:0];
        // a new event beats a clear in the same cycle
        evtStat_nxt = (evtStat_r & ~evtClr) | evtSet;
        evtEn_nxt = evtEn_r;
        if (regWr && isHit(regAddr, OFS_EVT_EN))
            evtEn_nxt = regWrData[EVT_W-1:0];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            evtStat_r <= RST_EVT;
            evtEn_r <= RST_EVT;
            rxAll_r <= 1'b1;
            txAll_r <= 1'b1;
        end else begin
            evtStat_r <= evtStat_nxt;
            evtEn_r <= evtEn_nxt;
            rxAll_r <= rxSt.allDone;
            txAll_r <= txSt.allDone;
        end
    end

    assign irq = |(evtStat_r & evtEn_r);
    assign rxBufferDone = rxSt.endFlag;
    assign rxAllBuffersDone = rxSt.allDone;
    assign txBufferDone = txSt.endFlag;
    assign txAllBuffersDone = txSt.allDone;

    // ------------------------------------------------------------------
    // read path: data stand only in the cycle after the strobe
    // ------------------------------------------------------------------
    logic [31:0] rd_r, rd_nxt;

    // write-only and unmapped addresses read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (regRd) begin
            case (regAddr)
                OFS_RX_PTR: rd_nxt = rxSt.curPtr;
                OFS_RX_CNT: rd_nxt = {16'h0000, rxSt.curCnt};
                OFS_TX_PTR: rd_nxt = txSt.curPtr;
                OFS_TX_CNT: rd_nxt = {16'h0000, txSt.curCnt};
                OFS_RX_NPTR: rd_nxt = rxSt.nxtPtr;
                OFS_RX_NCNT: rd_nxt = {16'h0000, rxSt.nxtCnt};
                OFS_TX_NPTR: rd_nxt = txSt.nxtPtr;
                OFS_TX_NCNT: rd_nxt = {16'h0000, txSt.nxtCnt};
                OFS_STATE: begin
                    rd_nxt[STATE_RX] = rxOn_r;
                    rd_nxt[STATE_TX] = txOn_r;
                end
                OFS_SIZE: begin
                    rd_nxt[SIZE_RX_LSB+:2] = rxSize_r;
                    rd_nxt[SIZE_TX_LSB+:2] = txSize_r;
                end
                OFS_EVT_STAT: rd_nxt[EVT_W-1:0] = evtStat_r;
                OFS_EVT_EN: rd_nxt[EVT_W-1:0] = evtEn_r;
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_r <= 32'h0000_0000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    assign regRdData = rd_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_rx_on_cmd: assert property (
        @(posedge clk) disable iff (reset)
        (cmdWr && regWrData[CMD_RX_ON] && !regWrData[CMD_RX_OFF])
        |=> rxOn_r)
        else $error("receive enable not taken");

    a_rx_off_wins: assert property (
        @(posedge clk) disable iff (reset)
        (cmdWr && regWrData[CMD_RX_OFF]) |=> !rxOn_r)
        else $error("receive disable lost");

    a_tx_on_cmd: assert property (
        @(posedge clk) disable iff (reset)
        (cmdWr && regWrData[CMD_TX_ON] && !regWrData[CMD_TX_OFF])
        |=> txOn_r)
        else $error("transmit enable not taken");

    a_tx_off_wins: assert property (
        @(posedge clk) disable iff (reset)
        (cmdWr && regWrData[CMD_TX_OFF])
        |=> !txOn_r)
        else $error("transmit disable lost");

    a_state_read: assert property (
        @(posedge clk) disable iff (reset)
        (regRd && isHit(regAddr, OFS_STATE)) |=>
        regRdData == {23'h0, $past(txOn_r), 7'h00, $past(rxOn_r)})
        else $error("enable state read wrong");

    a_tx_zero_gate: assert property (
        @(posedge clk) disable iff (reset)
        $rose(state_r == ST_TX) |-> $past(txSt.curCnt) != RST_CNT)
        else $error("transmit started with zero count");

    a_rx_ptr_step: assert property (
        @(posedge clk) disable iff (reset)
        (rxStep && rxWr == '0 && rxSt.curCnt > 16'h0001) |=>
        rxSt.curPtr == $past(rxSt.curPtr) + ptrStep($past(rxSize_r))
        && rxSt.curCnt == $past(rxSt.curCnt) - 16'h0001)
        else $error("receive pointer or count step wrong");

    a_rx_reload: assert property (
        @(posedge clk) disable iff (reset)
        (rxStep && rxWr == '0 && rxSt.curCnt == 16'h0001
         && rxSt.nxtCnt != RST_CNT) |=>
        rxSt.curCnt == $past(rxSt.nxtCnt) && rxSt.nxtCnt == RST_CNT
        && rxSt.curPtr == $past(rxSt.nxtPtr))
        else $error("following buffer not chained");

    a_tx_end_flag: assert property (
        @(posedge clk) disable iff (reset)
        (txStep && txWr == '0 && txSt.curCnt == 16'h0001) |=>
        txBufferDone ##1 evtStat_r[EVT_TX_DONE])
        else $error("transmit end flag or event missing");
    a_rx_end_clear: assert property (
        @(posedge clk) disable iff (reset)
        (rxWr.nxtCnt && !rxDoneEvt) |=> !rxBufferDone)
        else $error("receive end flag not cleared");
    c_rx_xfer: cover property (@(posedge clk) disable iff (reset)
        state_r == ST_RX && memDone);
    c_rx_chain: cover property (@(posedge clk) disable iff (reset)
        rxStep && rxSt.curCnt == 16'h0001 && rxSt.nxtCnt != RST_CNT);
    c_irq_rise: cover property (@(posedge clk) disable iff (reset)
        $rose(irq));
endmodule : peripheral_dma_next_buffer_ctrl

// *** bench/serial_peripheral_model.sv ***
// partner model: serial peripheral ready lines and memory responder
`timescale 1ns/1ns
module serial_peripheral_model
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bench control
    input wire logic rxLoad,
    input wire logic txLoad,
    input wire logic [7:0] loadNum,
    input wire logic [1:0] memLat,
    // block side
    input wire logic memReqValid,
    input mem_req_t memReq,
    output logic rxReady,
    output logic txReady,
    output logic memDone,
    output logic [7:0] served
);
    mem_req_t reqLog [0:15];
    logic [7:0] rxPend_r;
    logic [7:0] txPend_r;
    logic [1:0] wait_r;
    // ready drops while a transfer is in flight, so none is served twice
    assign rxReady = (rxPend_r != 8'h00) && !memReqValid;
    assign txReady = (txPend_r != 8'h00) && !memReqValid;
    // memory answers after memLat extra cycles, one pulse per transfer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxPend_r <= 8'h00;
            txPend_r <= 8'h00;
            wait_r <= 2'h0;
            memDone <= 1'b0;
            served <= 8'h00;
        end else begin
            memDone <= 1'b0;
            if (rxLoad) rxPend_r <= loadNum;
            if (txLoad) txPend_r <= loadNum;
            if (memReqValid && !memDone) begin
                if (wait_r == memLat) begin
                    memDone <= 1'b1;
                    wait_r <= 2'h0;
                    served <= served + 8'h01;
                    if (memReq.isTx) txPend_r <= txPend_r - 8'h01;
                    else rxPend_r <= rxPend_r - 8'h01;
                end else begin
                    wait_r <= wait_r + 2'h1;
                end
            end
        end
    end
    // log of requests, indexed by order of completion
    always_ff @(posedge clk) begin
        if (memReqValid && !memDone && wait_r == memLat) begin
            reqLog[served[3:0]] <= memReq;
        end
    end
endmodule : serial_peripheral_model

// *** bench/peripheral_dma_next_buffer_ctrl_bench.sv ***
// self-checking bench for the dma channel pair register block
`timescale 1ns/1ns
module peripheral_dma_next_buffer_ctrl_bench
    import dma_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk, reset, regWr, regRd, rxLoad, txLoad, memDone;
    logic rxReady, txReady, memReqValid, irq;
    logic rxBufferDone, rxAllBuffersDone, txBufferDone, txAllBuffersDone;
    logic [11:0] regAddr;
    logic [31:0] regWrData, regRdData, rdv;
    logic [7:0] loadNum, served;
    logic [1:0] memLat;
    mem_req_t memReq;
    int numErrors, testsRun, cycles;
    peripheral_dma_next_buffer_ctrl u_peripheral_dma_next_buffer_ctrl (
        .clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .rxReady(rxReady), .txReady(txReady),
        .rxBufferDone(rxBufferDone), .rxAllBuffersDone(rxAllBuffersDone),
        .txBufferDone(txBufferDone), .txAllBuffersDone(txAllBuffersDone),
        .memReqValid(memReqValid), .memReq(memReq), .memDone(memDone),
        .irq(irq));
    serial_peripheral_model u_serial_peripheral_model (
        .clk(clk), .reset(reset), .rxLoad(rxLoad), .txLoad(txLoad),
        .loadNum(loadNum), .memLat(memLat), .memReqValid(memReqValid),
        .memReq(memReq), .rxReady(rxReady), .txReady(txReady),
        .memDone(memDone), .served(served));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), regRdData, exp);
    endtask : rchk
    task automatic load(input logic tx, input logic [7:0] n);
        @(posedge clk);
        loadNum <= n;
        rxLoad <= !tx;
        txLoad <= tx;
        @(posedge clk);
        rxLoad <= 1'b0;
        txLoad <= 1'b0;
    endtask : load
    task automatic waitServed(input logic [7:0] n);
        for (int i = 0; i < 300 && served !== n; i++) @(negedge clk);
        chk("served", {24'h0, served}, {24'h0, n});
    endtask : waitServed
    task automatic xchk(input int k, input logic [31:0] a, input logic t);
        chk("addr", u_serial_peripheral_model.reqLog[k].addr, a);
        chk("dir", {31'h0, u_serial_peripheral_model.reqLog[k].isTx},
            {31'h0, t});
    endtask : xchk
    task automatic cmd(input logic [31:0] c, input logic [31:0] st);
        wr(OFS_CMD, c);
        rchk(OFS_STATE, st);
    endtask : cmd
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic resetValues();
        for (int a = 'h100; a <= 'h128; a += 4) rchk(a[11:0], 32'h0);
        rchk(12'h200, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        chk("rxAll", {31'h0, rxAllBuffersDone}, 32'h1);
    endtask : resetValues
    // following count written while current is nonzero, else it chains
    task automatic regWidths();
        wr(OFS_TX_CNT, 32'habcd_1234);
        rchk(OFS_TX_CNT, 32'h0000_1234);
        wr(OFS_RX_CNT, 32'h1);
        wr(OFS_RX_NCNT, 32'hffff_0005);
        rchk(OFS_RX_NCNT, 32'h5);
        wr(OFS_TX_NCNT, 32'hffff_0007);
        rchk(OFS_TX_NCNT, 32'h7);
        wr(OFS_RX_NPTR, 32'hdead_beef);
        rchk(OFS_RX_NPTR, 32'hdead_beef);
        wr(OFS_TX_NPTR, 32'h1234_5678);
        rchk(OFS_TX_NPTR, 32'h1234_5678);
        wr(OFS_RX_NCNT, 32'h0);
        wr(OFS_TX_NCNT, 32'h0);
        wr(OFS_RX_CNT, 32'h0);
        wr(OFS_TX_CNT, 32'h0);
    endtask : regWidths
    task automatic commands();
        cmd(32'h001, 32'h001);
        cmd(32'h003, 32'h000);
        cmd(32'h001, 32'h001);
        cmd(32'h000, 32'h001);
        cmd(32'h100, 32'h101);
        cmd(32'h300, 32'h001);
        cmd(32'h100, 32'h101);
        cmd(32'h200, 32'h001);
        cmd(32'h002, 32'h000);
        wr(OFS_STATE, 32'h101);
        rchk(OFS_STATE, 32'h0);
    endtask : commands
    // byte transfers chaining from the current into the following buffer
    task automatic rxChain();
        int b = served;
        memLat <= 2'h0;
        wr(OFS_EVT_CLR, 32'hf);
        wr(OFS_EVT_EN, 32'h1);
        wr(OFS_RX_PTR, 32'h1000);
        wr(OFS_RX_CNT, 32'h2);
        wr(OFS_RX_NPTR, 32'h2000);
        wr(OFS_RX_NCNT, 32'h1);
        wr(OFS_CMD, 32'h1);
        load(1'b0, 8'h03);
        waitServed(8'(b + 3));
        xchk(b, 32'h1000, 1'b0);
        xchk(b + 1, 32'h1001, 1'b0);
        xchk(b + 2, 32'h2000, 1'b0);
        rchk(OFS_RX_PTR, 32'h2001);
        rchk(OFS_RX_NCNT, 32'h0);
        chk("rxDone", {31'h0, rxBufferDone}, 32'h1);
        chk("rxAll", {31'h0, rxAllBuffersDone}, 32'h1);
        rchk(OFS_EVT_STAT, 32'h3);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(OFS_EVT_EN, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(OFS_RX_NCNT, 32'h0);
        chk("rxDone", {31'h0, rxBufferDone}, 32'h0);
        wr(OFS_EVT_CLR, 32'h3);
        rchk(OFS_EVT_STAT, 32'h0);
        wr(OFS_CMD, 32'h2);
    endtask : rxChain
    // two transfers then the peripheral keeps asking with count at zero
    task automatic txRun(input logic [1:0] sz, input logic [31:0] step,
                         input logic [1:0] lat);
        int b = served;
        @(posedge clk);
        memLat <= lat;
        wr(OFS_SIZE, {22'h0, sz, 8'h0});
        wr(OFS_TX_PTR, 32'h3000);
        wr(OFS_TX_CNT, 32'h2);
        load(1'b1, 8'h04);
        repeat (10) @(negedge clk);
        chk("served", {24'h0, served}, b);
        wr(OFS_CMD, 32'h100);
        waitServed(8'(b + 2));
        repeat (20) @(negedge clk);
        chk("served", {24'h0, served}, b + 2);
        xchk(b, 32'h3000, 1'b1);
        xchk(b + 1, 32'h3000 + step, 1'b1);
        chk("size", {30'h0, u_serial_peripheral_model.reqLog[b].size},
            {30'h0, sz});
        rchk(OFS_TX_CNT, 32'h0);
        chk("txAll", {31'h0, txAllBuffersDone}, 32'h1);
        chk("txDone", {31'h0, txBufferDone}, 32'h1);
        wr(OFS_TX_CNT, 32'h0);
        chk("txDone", {31'h0, txBufferDone}, 32'h0);
        wr(OFS_CMD, 32'h200);
        load(1'b1, 8'h00);
    endtask : txRun
    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic endSim();
        $display("checks %0d errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endSim
    always #5 clk = ~clk;
    // cut a hang short well beyond the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            endSim();
        end
    end
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {regWr, regRd, rxLoad, txLoad} = 4'h0;
        regAddr = 12'h000;
        regWrData = 32'h0;
        loadNum = 8'h00;
        memLat = 2'h0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        resetValues();
        regWidths();
        commands();
        rxChain();
        txRun(2'h2, 32'h4, 2'h3);
        txRun(2'h1, 32'h2, 2'h1);
        txRun(2'h3, 32'h4, 2'h0);
        endSim();
    end
endmodule : peripheral_dma_next_buffer_ctrl_bench
